/* File: src/sgfc_top.sv */
// Global forwarding control registers and the per-frame decisions they steer.
// Assumes register port and frame descriptors are synchronous to clk; port
// vectors are one bit per switch port, bit 4 being the switch MII port.
`timescale 1ns/10ps

// Notes on behaviour
// - Legal-max bit set allows frames to 1536.
// - Otherwise tagged 1522 (1518 with special CPU tag), untagged 1518 byte limits.
// - Frames longer than selected limit are dropped.
// - Reserve bit gives 48 high-priority buffers per queue.
// - VLAN enable turns tag-based VLAN forwarding on.
// - IGMP snoop sends IGMP frames to MII port.
// - Direct mode forwards MII frames by preamble ports.
// - Pre-tag marks MII-bound frames with source port.
// - Scheme field selects strict, 10/1, 5/1, 2/1.
// - Tag mask uses low VID bits as ports.
// - Sniff mode one mirrors on source AND destination.
// - Sniff mode zero mirrors on source OR destination.
// - Huge bit allows 1916 bytes, overrides legal-max.
module sgfc_top #(
	parameter int NPORTS = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Strap
	input wire logic port5_rx_error_strap_pin,
	// Management register port
	input wire logic [7:0] reg_addr,
	input wire logic [7:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [7:0] reg_rdata,
	// Frame descriptor in
	input wire logic frm_valid,
	input wire logic [10:0] frm_len,
	input wire logic frm_tagged,
	input wire logic frm_special_cpu_tag_id,
	input wire logic frm_igmp,
	input wire logic [11:0] frm_vid,
	input wire logic [NPORTS-1:0] frm_src_port,
	input wire logic [NPORTS-1:0] frm_lookup_ports,
	input wire logic [NPORTS-1:0] frm_direct_ports,
	input wire logic [NPORTS-1:0] frm_vlan_ports,
	input wire logic [NPORTS-1:0] sniff_rx_ports,
	input wire logic [NPORTS-1:0] sniff_tx_ports,
	// Forwarding decision out
	output logic fwd_valid,
	output logic fwd_drop,
	output logic [NPORTS-1:0] fwd_ports,
	output logic fwd_mirror,
	output logic fwd_pretag,
	output logic [NPORTS-1:0] fwd_pretag_src,
	// Output scheduler
	input wire logic sched_req,
	input wire logic sched_hi_pending,
	input wire logic sched_lo_pending,
	output logic sched_grant_hi,
	output logic sched_grant_lo,
	// Static controls
	output logic [5:0] hi_reserve_bufs,
	output logic vlan_enable
);

	// ==========================================================
	// Register state
	logic huge_pkt;
	logic legal_max;
	logic prio_reserve;
	logic [7:0] fwd_feature;
	logic strap_taken;

	logic wr_size;
	logic wr_feature;
	assign wr_size = reg_wr && (reg_addr == sgfc_pkg::PKT_SIZE_BUF_CTRL_OFS);
	assign wr_feature = reg_wr && (reg_addr == sgfc_pkg::FWD_FEATURE_CTRL_OFS);

	// Huge and reserve bits of the size register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			huge_pkt <= sgfc_pkg::HUGE_PKT_RST;
			prio_reserve <= sgfc_pkg::PRIO_RESERVE_RST;
		end else if (wr_size) begin
			huge_pkt <= reg_wdata[sgfc_pkg::HUGE_PKT_BIT];
			prio_reserve <= reg_wdata[sgfc_pkg::PRIO_RESERVE_BIT];
		end
	end

	// Legal-max bit, loaded from the strap on the first edge after reset
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			legal_max <= 1'b0;
			strap_taken <= 1'b0;
		end else if (!strap_taken) begin
			legal_max <= port5_rx_error_strap_pin;
			strap_taken <= 1'b1;
		end else if (wr_size) begin
			legal_max <= reg_wdata[sgfc_pkg::LEGAL_MAX_BIT];
		end
	end

	// Forwarding feature register
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fwd_feature <= sgfc_pkg::FWD_FEATURE_RST;
		end else if (wr_feature) begin
			fwd_feature <= reg_wdata;
		end
	end

	// Read data, captured on a read strobe; unmapped addresses read zero
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			reg_rdata <= 8'h00;
		end else if (reg_rd) begin
			case (reg_addr)
				sgfc_pkg::PKT_SIZE_BUF_CTRL_OFS: begin
					reg_rdata <= {5'h00, huge_pkt, legal_max, prio_reserve};
				end
				sgfc_pkg::FWD_FEATURE_CTRL_OFS: begin
					reg_rdata <= fwd_feature;
				end
				default: begin
					reg_rdata <= 8'h00;
				end
			endcase
		end
	end

	// ==========================================================
	// Field decode
	logic vlan_en_f;
	logic igmp_snoop_f;
	logic direct_mode_f;
	logic pre_tag_f;
	logic tag_mask_f;
	logic sniff_and_f;
	sgfc_pkg::sgfc_prio_t prio_scheme;
	assign vlan_en_f = fwd_feature[sgfc_pkg::VLAN_EN_BIT];
	assign igmp_snoop_f = fwd_feature[sgfc_pkg::IGMP_SNOOP_BIT];
	assign direct_mode_f = fwd_feature[sgfc_pkg::DIRECT_MODE_BIT];
	assign pre_tag_f = fwd_feature[sgfc_pkg::PRE_TAG_BIT];
	assign tag_mask_f = fwd_feature[sgfc_pkg::TAG_MASK_BIT];
	assign sniff_and_f = fwd_feature[sgfc_pkg::SNIFF_MODE_BIT];
	assign prio_scheme = sgfc_pkg::sgfc_prio_t'(
		fwd_feature[sgfc_pkg::PRIO_SCHEME_HI:sgfc_pkg::PRIO_SCHEME_LO]);

	// Static control outputs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			hi_reserve_bufs <= 6'h00;
			vlan_enable <= 1'b0;
		end else begin
			hi_reserve_bufs <= prio_reserve ? sgfc_pkg::HI_RESERVE_BUFS : 6'h00;
			vlan_enable <= vlan_en_f;
		end
	end

	// ==========================================================
	// Per-frame decision
	logic [10:0] len_limit;
	logic from_mii;
	logic [NPORTS-1:0] next_ports;
	logic rx_match;
	logic tx_match;
	logic next_mirror;

	// Length limit selection
	always_comb begin
		if (huge_pkt) begin
			len_limit = sgfc_pkg::LEN_LIMIT_HUGE;
		end else if (legal_max) begin
			len_limit = sgfc_pkg::LEN_LIMIT_LEGAL;
		end else if (frm_tagged && !frm_special_cpu_tag_id) begin
			len_limit = sgfc_pkg::LEN_LIMIT_TAGGED;
		end else begin
			len_limit = sgfc_pkg::LEN_LIMIT_UNTAGGED;
		end
	end

	assign from_mii = frm_src_port[sgfc_pkg::MII_PORT_IDX];

	// Destination selection: direct, tag mask, or lookup masked by VLAN, then IGMP
	always_comb begin
		if (direct_mode_f && from_mii) begin
			next_ports = frm_direct_ports;
		end else if (tag_mask_f) begin
			next_ports = frm_vid[NPORTS-1:0];
		end else if (vlan_en_f) begin
			next_ports = frm_lookup_ports & frm_vlan_ports;
		end else begin
			next_ports = frm_lookup_ports;
		end
		if (igmp_snoop_f && frm_igmp) begin
			next_ports[sgfc_pkg::MII_PORT_IDX] = 1'b1;
		end
		next_ports = next_ports & ~frm_src_port;
	end

	assign rx_match = |(frm_src_port & sniff_rx_ports);
	assign tx_match = |(next_ports & sniff_tx_ports);
	assign next_mirror = sniff_and_f ? (rx_match && tx_match) : (rx_match || tx_match);

	// Registered decision
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			fwd_valid <= 1'b0;
			fwd_drop <= 1'b0;
			fwd_ports <= '0;
			fwd_mirror <= 1'b0;
			fwd_pretag <= 1'b0;
			fwd_pretag_src <= '0;
		end else begin
			fwd_valid <= frm_valid;
			fwd_drop <= frm_valid && (frm_len > len_limit);
			fwd_ports <= frm_valid ? next_ports : '0;
			fwd_mirror <= frm_valid && next_mirror;
			fwd_pretag <= frm_valid && pre_tag_f && next_ports[sgfc_pkg::MII_PORT_IDX];
			fwd_pretag_src <= frm_valid ? frm_src_port : '0;
		end
	end

	// ==========================================================
	// High/low output scheduler
	logic [3:0] hi_run;
	logic [3:0] ratio;

	always_comb begin
		case (prio_scheme)
			sgfc_pkg::SGFC_PRIO_10_1: ratio = sgfc_pkg::RATIO_10_TO_1;
			sgfc_pkg::SGFC_PRIO_5_1: ratio = sgfc_pkg::RATIO_5_TO_1;
			sgfc_pkg::SGFC_PRIO_2_1: ratio = sgfc_pkg::RATIO_2_TO_1;
			default: ratio = 4'h0;
		endcase
	end

	// Grant one queue per request; outside strict, a low grant follows each ratio run of highs
	always_ff @(posedge clk or posedge rst) begin
		if (rst) begin
			sched_grant_hi <= 1'b0;
			sched_grant_lo <= 1'b0;
			hi_run <= 4'h0;
		end else begin
			sched_grant_hi <= 1'b0;
			sched_grant_lo <= 1'b0;
			if (sched_req) begin
				if (sched_hi_pending && (!sched_lo_pending ||
					prio_scheme == sgfc_pkg::SGFC_PRIO_STRICT || hi_run < ratio)) begin
					sched_grant_hi <= 1'b1;
					if (sched_lo_pending && hi_run < ratio) begin
						hi_run <= hi_run + 4'h1;
					end
				end else if (sched_lo_pending) begin
					sched_grant_lo <= 1'b1;
					hi_run <= 4'h0;
				end
			end
		end
	end

endmodule : sgfc_top

/* File: src/sgfc_pkg.sv */
// Package for the switch global forwarding control block.
// Holds register offsets, field positions, reset values and forwarding limits.
// Assumes an 8-bit management register port with 8-bit addresses.
package sgfc_pkg;
	// ==========================================================
	// Register offsets
	localparam logic [7:0] PKT_SIZE_BUF_CTRL_OFS = 8'h04;
	localparam logic [7:0] FWD_FEATURE_CTRL_OFS = 8'h05;

	// ==========================================================
	// Field positions in packet_size_buffer_ctrl
	localparam int HUGE_PKT_BIT = 2;
	localparam int LEGAL_MAX_BIT = 1;
	localparam int PRIO_RESERVE_BIT = 0;

	// ==========================================================
	// Field positions in forwarding_feature_ctrl
	localparam int VLAN_EN_BIT = 7;
	localparam int IGMP_SNOOP_BIT = 6;
	localparam int DIRECT_MODE_BIT = 5;
	localparam int PRE_TAG_BIT = 4;
	localparam int PRIO_SCHEME_HI = 3;
	localparam int PRIO_SCHEME_LO = 2;
	localparam int TAG_MASK_BIT = 1;
	localparam int SNIFF_MODE_BIT = 0;

	// ==========================================================
	// Reset values
	localparam logic HUGE_PKT_RST = 1'b0;
	localparam logic PRIO_RESERVE_RST = 1'b0;
	localparam logic [7:0] FWD_FEATURE_RST = 8'h00;

	// ==========================================================
	// Frame length limits in bytes
	localparam logic [10:0] LEN_LIMIT_LEGAL = 11'h600;   // 1536
	localparam logic [10:0] LEN_LIMIT_TAGGED = 11'h5F2;  // 1522
	localparam logic [10:0] LEN_LIMIT_UNTAGGED = 11'h5EE; // 1518
	localparam logic [10:0] LEN_LIMIT_HUGE = 11'h77C;    // 1916

	// ==========================================================
	// Buffer reservation and scheduling weights
	localparam logic [5:0] HI_RESERVE_BUFS = 6'h30;      // 48
	localparam logic [3:0] RATIO_10_TO_1 = 4'hA;
	localparam logic [3:0] RATIO_5_TO_1 = 4'h5;
	localparam logic [3:0] RATIO_2_TO_1 = 4'h2;

	// Priority scheme encodings
	typedef enum logic [1:0] {
		SGFC_PRIO_STRICT = 2'h0,
		SGFC_PRIO_10_1 = 2'h1,
		SGFC_PRIO_5_1 = 2'h2,
		SGFC_PRIO_2_1 = 2'h3
	} sgfc_prio_t;

	// Port index of the switch MII port (port 5)
	localparam int MII_PORT_IDX = 4;
endpackage : sgfc_pkg

/* File: testbench/sgfc_chk.sv */
// Port assertions for the global forwarding control block.
// Assumes rising-edge clk and active-high asynchronous rst.
`timescale 1ns/10ps
// ==========================================
// Checker
module sgfc_chk #(
	parameter int NPORTS = 5
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst,
	// Watched ports
	input wire logic frm_valid,
	input wire logic [10:0] frm_len,
	input wire logic fwd_valid,
	input wire logic fwd_drop,
	input wire logic [NPORTS-1:0] fwd_ports,
	input wire logic fwd_pretag,
	input wire logic sched_req,
	input wire logic sched_hi_pending,
	input wire logic sched_lo_pending,
	input wire logic sched_grant_hi,
	input wire logic sched_grant_lo,
	input wire logic [5:0] hi_reserve_bufs
);
	default clocking @(posedge clk);
	endclocking
	default disable iff (rst);
	// Frame decisions
	decision_due_a: assert property (frm_valid |=> fwd_valid)
		else $error("decision missing");
	huge_over_a: assert property (frm_valid && frm_len > 11'h77C |=> fwd_drop)
		else $error("oversize frame kept");
	base_len_a: assert property (frm_valid && frm_len <= 11'h5EE |=> !fwd_drop)
		else $error("short frame dropped");
	drop_valid_a: assert property (fwd_drop |-> fwd_valid)
		else $error("drop without decision");
	pretag_mii_a: assert property (fwd_pretag |-> fwd_ports[sgfc_pkg::MII_PORT_IDX])
		else $error("pre-tag without MII port");
	reserve_val_a: assert property (hi_reserve_bufs == 6'h00 || hi_reserve_bufs == 6'h30)
		else $error("bad reserve count");
	// Scheduler grants
	grant_one_a: assert property (!(sched_grant_hi && sched_grant_lo))
		else $error("two grants");
	grant_idle_a: assert property (sched_req && !sched_hi_pending && !sched_lo_pending
		|=> !sched_grant_hi && !sched_grant_lo) else $error("grant with nothing pending");
	grant_hi_a: assert property (sched_grant_hi |-> $past(sched_req && sched_hi_pending))
		else $error("high grant without cause");
endmodule : sgfc_chk

bind sgfc_top sgfc_chk #(.NPORTS(NPORTS)) chk_i (.clk, .rst, .frm_valid, .frm_len, .fwd_valid,
	.fwd_drop, .fwd_ports, .fwd_pretag, .sched_req, .sched_hi_pending, .sched_lo_pending,
	.sched_grant_hi, .sched_grant_lo, .hi_reserve_bufs);

/* File: testbench/testbench.sv */
// Self-checking bench for the global forwarding control block.
// Assumes sgfc_top, 125 MHz clk and active-high asynchronous rst.
`timescale 1ns/10ps
// ==========================================
// Bench
module testbench;
	logic clk, rst, port5_rx_error_strap_pin, reg_wr, reg_rd, frm_valid, frm_tagged;
	logic frm_special_cpu_tag_id, frm_igmp, sched_req, sched_hi_pending, sched_lo_pending;
	logic fwd_valid, fwd_drop, fwd_mirror, fwd_pretag, sched_grant_hi, sched_grant_lo;
	logic vlan_enable;
	logic [7:0] reg_addr, reg_wdata, reg_rdata;
	logic [10:0] frm_len;
	logic [11:0] frm_vid;
	logic [4:0] frm_src_port, frm_lookup_ports, frm_direct_ports, frm_vlan_ports;
	logic [4:0] sniff_rx_ports, sniff_tx_ports, fwd_ports, fwd_pretag_src;
	logic [5:0] hi_reserve_bufs;
	int n_mismatch = 0;
	int n_checks = 0;

	// Device under test
	sgfc_top #(.NPORTS(5)) uut (.clk, .rst, .port5_rx_error_strap_pin, .reg_addr, .reg_wdata,
		.reg_wr, .reg_rd, .reg_rdata, .frm_valid, .frm_len, .frm_tagged,
		.frm_special_cpu_tag_id, .frm_igmp, .frm_vid, .frm_src_port, .frm_lookup_ports,
		.frm_direct_ports, .frm_vlan_ports, .sniff_rx_ports, .sniff_tx_ports, .fwd_valid,
		.fwd_drop, .fwd_ports, .fwd_mirror, .fwd_pretag, .fwd_pretag_src, .sched_req,
		.sched_hi_pending, .sched_lo_pending, .sched_grant_hi, .sched_grant_lo,
		.hi_reserve_bufs, .vlan_enable);

	// Clock
	initial begin
		clk = 1'b0;
		forever #4 clk = ~clk;
	end

	task automatic chk(input string what, input logic [15:0] seen, input logic [15:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", what, exp, seen);
		end
	endtask : chk

	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk) #1;
		reg_addr = a;
		reg_wdata = d;
		reg_wr = 1'b1;
		@(posedge clk) #1;
		reg_wr = 1'b0;
	endtask : wr

	task automatic rd(input logic [7:0] a, input logic [7:0] exp);
		@(posedge clk) #1;
		reg_addr = a;
		reg_rd = 1'b1;
		@(posedge clk) #1;
		reg_rd = 1'b0;
		chk("reg_rdata", reg_rdata, exp);
	endtask : rd

	task automatic frm(input logic [10:0] len, input logic [4:0] src, input logic [4:0] lk);
		@(posedge clk) #1;
		frm_len = len;
		frm_src_port = src;
		frm_lookup_ports = lk;
		frm_valid = 1'b1;
		@(posedge clk) #1;
		frm_valid = 1'b0;
		chk("fwd_valid", fwd_valid, 1'b1);
	endtask : frm

	task automatic t_len;
		logic [19:0] tc [9] = '{20'h005EE, 20'h015EF, 20'h045F2, 20'h055F3, 20'h075EF,
			20'h24600, 20'h21601, 20'h6077C, 20'h6177D};
		for (int i = 0; i < 9; i++) begin
			wr(8'h04, {4'h0, tc[i][19:16]});
			frm_tagged = tc[i][14];
			frm_special_cpu_tag_id = tc[i][13];
			frm(tc[i][10:0], 5'h01, 5'h02);
			chk("fwd_drop", fwd_drop, tc[i][12]);
		end
		$display("t_len done");
	endtask : t_len

	task automatic t_regs;
		rd(8'h04, 8'h02);
		rd(8'h05, 8'h00);
		rd(8'h06, 8'h00);
		wr(8'h04, 8'h01);
		@(posedge clk) #1;
		chk("hi_reserve_bufs", hi_reserve_bufs, 6'h30);
		wr(8'h04, 8'h00);
		@(posedge clk) #1;
		chk("hi_reserve_bufs", hi_reserve_bufs, 6'h00);
		$display("t_regs done");
	endtask : t_regs

	task automatic t_fwd;
		wr(8'h05, 8'h80);
		rd(8'h05, 8'h80);
		chk("vlan_enable", vlan_enable, 1'b1);
		frm(11'h040, 5'h01, 5'h07);
		chk("fwd_ports", fwd_ports, 5'h04);
		wr(8'h05, 8'h40);
		frm_igmp = 1'b1;
		frm(11'h040, 5'h01, 5'h02);
		chk("fwd_ports", fwd_ports, 5'h12);
		wr(8'h05, 8'h00);
		frm(11'h040, 5'h01, 5'h07);
		chk("fwd_ports", fwd_ports, 5'h06);
		frm_igmp = 1'b0;
		wr(8'h05, 8'h20);
		frm(11'h040, 5'h10, 5'h02);
		chk("fwd_ports", fwd_ports, 5'h04);
		wr(8'h05, 8'h10);
		frm(11'h040, 5'h01, 5'h10);
		chk("fwd_pretag", {fwd_pretag, fwd_pretag_src}, 6'h21);
		wr(8'h05, 8'h02);
		frm_vid = 12'h7EC;
		frm(11'h040, 5'h01, 5'h01);
		chk("fwd_ports", fwd_ports, 5'h0C);
		wr(8'h05, 8'h01);
		frm(11'h040, 5'h08, 5'h02);
		chk("fwd_mirror", fwd_mirror, 1'b0);
		frm(11'h040, 5'h08, 5'h10);
		chk("fwd_mirror", fwd_mirror, 1'b1);
		wr(8'h05, 8'h00);
		frm(11'h040, 5'h08, 5'h02);
		chk("fwd_mirror", fwd_mirror, 1'b1);
		frm(11'h040, 5'h01, 5'h10);
		chk("fwd_mirror", fwd_mirror, 1'b1);
		$display("t_fwd done");
	endtask : t_fwd

	task automatic t_sched;
		int hi;
		int r [4] = '{4, 10, 5, 2};
		// reserve set while priority queues run
		wr(8'h04, 8'h01);
		sched_hi_pending = 1'b1;
		sched_lo_pending = 1'b1;
		for (int s = 1; s < 5; s++) begin
			wr(8'h05, {4'h0, 2'(s), 2'h0});
			hi = 0;
			sched_req = 1'b1;
			for (int k = 0; k <= r[s % 4]; k++) begin
				@(posedge clk) #1;
				hi += int'(sched_grant_hi);
			end
			sched_req = 1'b0;
			chk("hi grants", 16'(hi), 16'(r[s % 4] + (s == 4)));
			chk("last low", sched_grant_lo, (s != 4));
		end
		$display("t_sched done");
	endtask : t_sched

	task automatic t_strap;
		wr(8'h05, 8'hFF);
		wr(8'h04, 8'h07);
		@(posedge clk) #1;
		port5_rx_error_strap_pin = 1'b0;
		rst = 1'b1;
		repeat (2) @(posedge clk);
		#1 rst = 1'b0;
		rd(8'h04, 8'h00);
		rd(8'h05, 8'h00);
		@(posedge clk) #1;
		chk("hi_reserve_bufs", hi_reserve_bufs, 6'h00);
		chk("vlan_enable", vlan_enable, 1'b0);
		$display("t_strap done");
	endtask : t_strap

	task automatic finish_test;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("STATUS OK");
		end else begin
			$display("STATUS NOT OK");
		end
		$finish;
	endtask : finish_test

	// Watchdog
	initial begin
		#100000;
		n_mismatch++;
		finish_test;
	end

	// Reset and test sequence
	initial begin
		{reg_wr, reg_rd, frm_valid, frm_tagged, frm_special_cpu_tag_id, frm_igmp} = 6'h00;
		{sched_req, sched_hi_pending, sched_lo_pending, reg_addr, reg_wdata} = 19'h00000;
		{frm_len, frm_vid, frm_src_port, frm_lookup_ports} = 33'h00000000C;
		{frm_direct_ports, frm_vlan_ports, sniff_rx_ports, sniff_tx_ports} = 20'hA3110;
		port5_rx_error_strap_pin = 1'b1;
		rst = 1'b1;
		repeat (12) @(posedge clk);
		#1 rst = 1'b0;
		t_regs();
		t_len();
		t_fwd();
		t_sched();
		t_strap();
		finish_test();
	end
endmodule : testbench
